// File: core/lfd_pkg.sv
package lfd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned CLK_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;
    localparam int unsigned DEBOUNCE_MS  = 37;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_PER_MS;
    localparam int unsigned PWM_HZ       = 220;
    localparam int unsigned DUTY_SCALE   = 1000;
    localparam int unsigned SLOT_CYC     = CLK_HZ / (PWM_HZ * DUTY_SCALE);
    localparam int unsigned GAMMA_STEPS  = 63;
    localparam logic [5:0]  TOP_IDX      = 6'h3E;
    localparam int unsigned FADE_UNIT_MS = 7;
    // 2.5 us per ohm, held as us per kilohm
    localparam int unsigned RES_US_PER_KOHM = 2500;
    localparam int unsigned CANCEL_US    = 75;
    localparam logic [19:0] STEP_REG_CYC =
        20'(FADE_UNIT_MS * CLK_PER_MS / GAMMA_STEPS);
    localparam logic [19:0] STEP_RES_CYC =
        20'(RES_US_PER_KOHM * CLK_PER_US / GAMMA_STEPS);
    localparam logic [19:0] STEP_CANCEL_CYC =
        20'(CANCEL_US * CLK_PER_US / GAMMA_STEPS);

    ////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] ADDR_CFG      = 8'h01;
    localparam logic [7:0] ADDR_FADE_ON  = 8'h03;
    localparam logic [7:0] ADDR_FADE_OFF = 8'h04;
    localparam logic [7:0] ADDR_CTRL     = 8'h07;
    localparam logic [7:0] ADDR_STATUS   = 8'h0B;
    localparam logic [7:0] ADDR_IDX1     = 8'h0C;
    localparam logic [7:0] ADDR_IDX2     = 8'h0D;
    localparam int unsigned CFG_FIT_BIT  = 0;
    localparam int unsigned CFG_FOT_BIT  = 1;
    localparam int unsigned CFG_PWMM_BIT = 2;
    localparam int unsigned CFG_ENM_BIT  = 3;
    localparam int unsigned CTRL_PWME_BIT = 0;
    localparam logic [3:0] CFG_RST       = 4'h0;
    localparam logic [7:0] FADE_RST      = 8'h00;
    localparam logic       CTRL_RST      = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic en_m;
        logic pwm_m;
        logic fade_out_source_select;
        logic fade_in_source_select;
    } lfd_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lfd_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } lfd_reg_rsp_t;

    ////////////////////////////////////////////////////////////////////////
    // Gamma duty table, scale of 1000
    localparam logic [9:0] GAMMA [0:62] = '{
        10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00A, 10'h00C,
        10'h010, 10'h014, 10'h018, 10'h01C, 10'h020, 10'h024, 10'h02A,
        10'h030, 10'h036, 10'h03C, 10'h042, 10'h048, 10'h050, 10'h058,
        10'h060, 10'h068, 10'h070, 10'h078, 10'h082, 10'h08C, 10'h096,
        10'h0A0, 10'h0AA, 10'h0B4, 10'h0C2, 10'h0D0, 10'h0DE, 10'h0EC,
        10'h0FA, 10'h108, 10'h11A, 10'h12C, 10'h13E, 10'h150, 10'h162,
        10'h174, 10'h18A, 10'h1A0, 10'h1B6, 10'h1CC, 10'h1E2, 10'h1F8,
        10'h216, 10'h234, 10'h252, 10'h270, 10'h28E, 10'h2AC, 10'h2D2,
        10'h2F8, 10'h31E, 10'h344, 10'h36A, 10'h392, 10'h3BC, 10'h3E8
    };

    function automatic logic [9:0] lfd_gamma(input logic [5:0] idx);
        lfd_gamma = (idx > TOP_IDX) ? GAMMA[62] : GAMMA[idx];
    endfunction : lfd_gamma

    // Cycles spent on one gamma step for the selected fade source
    function automatic logic [19:0] lfd_step_cyc(
        input logic       sel,
        input logic [7:0] regv,
        input logic [9:0] kohm
    );
        if (sel) begin
            lfd_step_cyc = (regv == 8'h00) ? STEP_CANCEL_CYC
                         : 20'(20'(regv) * STEP_REG_CYC);
        end else begin
            lfd_step_cyc = (kohm == 10'h000) ? STEP_CANCEL_CYC
                         : 20'(20'(kohm) * STEP_RES_CYC);
        end
    endfunction : lfd_step_cyc

endpackage : lfd_pkg

// File: core/lfd_debounce.sv
`timescale 1ns/100ps
`default_nettype none
module lfd_debounce #(
    parameter int unsigned DB_CYC = 370000
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Same-clock input
    input  wire logic raw,
    // Debounced level and edge pulses
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic [19:0] cnt_r;

    // Both edges must hold for the full time before the level moves
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt_r <= 20'h00000;
            level <= 1'b0;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (raw == level) begin
                cnt_r <= 20'h00000;
            end else if (cnt_r == 20'(DB_CYC - 1)) begin
                cnt_r <= 20'h00000;
                level <= raw;
                rise  <= raw;
                fall  <= ~raw;
            end else begin
                cnt_r <= cnt_r + 20'h00001;
            end
        end
    end

endmodule : lfd_debounce
`default_nettype wire

// File: core/lfd_pwm_base.sv
`timescale 1ns/100ps
`default_nettype none
module lfd_pwm_base (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // Duty slot, 0 to 999 within one 220 Hz frame
    output logic [9:0]      slot
);

    logic [7:0] sub_r;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sub_r <= 8'h00;
            slot  <= 10'h000;
        end else if (sub_r == 8'(lfd_pkg::SLOT_CYC - 1)) begin
            sub_r <= 8'h00;
            slot  <= (slot == 10'(lfd_pkg::DUTY_SCALE - 1))
                   ? 10'h000 : slot + 10'h001;
        end else begin
            sub_r <= sub_r + 8'h01;
        end
    end

endmodule : lfd_pwm_base
`default_nettype wire

// File: core/lfd_fade_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module lfd_fade_ctrl #(
    parameter int unsigned DEBOUNCE_CYC = lfd_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Register port
    input  wire lfd_pkg::lfd_reg_req_t reg_req,
    output lfd_pkg::lfd_reg_rsp_t     reg_rsp,
    // Channel enable pins, asynchronous
    input  wire logic [1:0]           channel_enable_pins,
    // Fade resistor values in kilohm, zero when grounded
    input  wire logic [9:0]           rise_time_resistor_pin,
    input  wire logic [9:0]           fall_time_resistor_pin,
    // Supply comparators, asynchronous
    input  wire logic                 supply_below_lock,
    input  wire logic                 supply_below_hold,
    input  wire logic                 supply_above_resume,
    // Current source gates
    output logic [1:0]                high_current_outputs
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    lfd_pkg::lfd_cfg_t cfg_r;
    logic [7:0]        fade_on_time_r;
    logic [7:0]        fade_off_time_r;
    logic              pwm_e_r;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cfg_r           <= lfd_pkg::CFG_RST;
            fade_on_time_r  <= lfd_pkg::FADE_RST;
            fade_off_time_r <= lfd_pkg::FADE_RST;
            pwm_e_r         <= lfd_pkg::CTRL_RST;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                lfd_pkg::ADDR_CFG: begin
                    cfg_r.fade_in_source_select   <= reg_req.wdata[lfd_pkg::CFG_FIT_BIT];
                    cfg_r.fade_out_source_select   <= reg_req.wdata[lfd_pkg::CFG_FOT_BIT];
                    cfg_r.pwm_m <= reg_req.wdata[lfd_pkg::CFG_PWMM_BIT];
                    cfg_r.en_m  <= reg_req.wdata[lfd_pkg::CFG_ENM_BIT];
                end
                lfd_pkg::ADDR_FADE_ON:  fade_on_time_r  <= reg_req.wdata;
                lfd_pkg::ADDR_FADE_OFF: fade_off_time_r <= reg_req.wdata;
                lfd_pkg::ADDR_CTRL: begin
                    pwm_e_r <= reg_req.wdata[lfd_pkg::CTRL_PWME_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0]  en_s1_r;
    logic [1:0]  en_s2_r;
    logic [2:0]  sup_s1_r;
    logic [2:0]  sup_s2_r;
    logic [19:0] res_s1_r;
    logic [19:0] res_s2_r;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            en_s1_r  <= 2'h0;
            en_s2_r  <= 2'h0;
            sup_s1_r <= 3'h0;
            sup_s2_r <= 3'h0;
            res_s1_r <= 20'h00000;
            res_s2_r <= 20'h00000;
        end else begin
            en_s1_r  <= channel_enable_pins;
            en_s2_r  <= en_s1_r;
            sup_s1_r <= {supply_above_resume, supply_below_hold,
                         supply_below_lock};
            sup_s2_r <= sup_s1_r;
            res_s1_r <= {fall_time_resistor_pin, rise_time_resistor_pin};
            res_s2_r <= res_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debounce of both pins and of the software bit
    logic [1:0] en_lvl;
    logic [1:0] en_rise;
    logic [1:0] en_fall;
    logic       sw_lvl;
    logic       sw_rise;
    logic       sw_fall;

    for (genvar g = 0; g < 2; g++) begin : g_en_db
        lfd_debounce #(
            .DB_CYC (DEBOUNCE_CYC)
        ) u_en_db (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .raw      (en_s2_r[g]),
            .level    (en_lvl[g]),
            .rise     (en_rise[g]),
            .fall     (en_fall[g])
        );
    end

    // Soft bit is same-clock: no synchroniser
    lfd_debounce #(
        .DB_CYC (DEBOUNCE_CYC)
    ) u_sw_db (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .raw      (pwm_e_r),
        .level    (sw_lvl),
        .rise     (sw_rise),
        .fall     (sw_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Undervoltage lockout
    logic uvlo_r;
    logic hold_lost;

    assign hold_lost = sup_s2_r[1];

    // Locks on either low level; frees only on resume
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            uvlo_r <= 1'b0;
        end else if (sup_s2_r[0] || hold_lost) begin
            uvlo_r <= 1'b1;
        end else if (sup_s2_r[2]) begin
            uvlo_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger arbitration
    // Pin event beats same-cycle soft event
    logic [1:0] on_r;
    logic [1:0] req_v;
    logic [1:0] req_val;

    always_comb begin
        logic sw_v;
        logic en_v;
        logic en_val;

        en_v   = 1'b0;
        en_val = 1'b0;
        sw_v = ~cfg_r.pwm_m & (sw_rise | sw_fall);
        for (int i = 0; i < 2; i++) begin
            if (cfg_r.en_m) begin
                en_v   = en_fall[i];
                en_val = ~on_r[i];
            end else begin
                en_v   = en_rise[i] | en_fall[i];
                en_val = en_rise[i];
            end
            req_v[i]   = en_v | sw_v;
            req_val[i] = en_v ? en_val : sw_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp state per channel
    logic [5:0]  idx_r [0:1];
    logic [19:0] tmr_r [0:1];
    logic [19:0] up_len;
    logic [19:0] dn_len;

    // Step share of the fade used up
    function automatic logic step_done(
        input logic [19:0] tmr,
        input logic [19:0] len
    );
        step_done = tmr >= len - 20'h00001;
    endfunction : step_done

    assign up_len = lfd_pkg::lfd_step_cyc(cfg_r.fade_in_source_select, fade_on_time_r,
                                          res_s2_r[9:0]);
    assign dn_len = lfd_pkg::lfd_step_cyc(cfg_r.fade_out_source_select, fade_off_time_r,
                                          res_s2_r[19:10]);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            on_r <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                idx_r[i] <= 6'h00;
                tmr_r[i] <= 20'h00000;
            end
        end else if (hold_lost) begin
            on_r <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                idx_r[i] <= 6'h00;
                tmr_r[i] <= 20'h00000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (req_v[i] && (req_val[i] != on_r[i])) begin
                    on_r[i]  <= req_val[i];
                    tmr_r[i] <= 20'h00000;
                end else if (on_r[i] && idx_r[i] != lfd_pkg::TOP_IDX) begin
                    if (step_done(tmr_r[i], up_len)) begin
                        tmr_r[i] <= 20'h00000;
                        idx_r[i] <= idx_r[i] + 6'h01;
                    end else begin
                        tmr_r[i] <= tmr_r[i] + 20'h00001;
                    end
                end else if (!on_r[i] && idx_r[i] != 6'h00) begin
                    if (step_done(tmr_r[i], dn_len)) begin
                        tmr_r[i] <= 20'h00000;
                        idx_r[i] <= idx_r[i] - 6'h01;
                    end else begin
                        tmr_r[i] <= tmr_r[i] + 20'h00001;
                    end
                end else begin
                    tmr_r[i] <= 20'h00000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output modulation
    logic [9:0] slot;

    lfd_pwm_base u_pwm_base (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .slot     (slot)
    );

    // Ramp runs on under lockout unless below hold level; only gates forced off
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            high_current_outputs <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (uvlo_r) begin
                    high_current_outputs[i] <= 1'b0;
                end else if (cfg_r.pwm_m) begin
                    high_current_outputs[i] <= pwm_e_r;
                end else begin
                    high_current_outputs[i] <=
                        slot < lfd_pkg::lfd_gamma(idx_r[i]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rsp <= '0;
        end else begin
            reg_rsp.valid <= reg_req.rd;
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    lfd_pkg::ADDR_CFG:      reg_rsp.data <= {4'h0, cfg_r};
                    lfd_pkg::ADDR_FADE_ON:  reg_rsp.data <= fade_on_time_r;
                    lfd_pkg::ADDR_FADE_OFF: reg_rsp.data <= fade_off_time_r;
                    lfd_pkg::ADDR_CTRL:     reg_rsp.data <= {7'h00, pwm_e_r};
                    lfd_pkg::ADDR_STATUS: begin
                        // Pins 5:4, soft 3, lockout 2, latches 1:0
                        reg_rsp.data <= {2'h0, en_lvl, sw_lvl, uvlo_r, on_r};
                    end
                    lfd_pkg::ADDR_IDX1:     reg_rsp.data <= {2'h0, idx_r[0]};
                    lfd_pkg::ADDR_IDX2:     reg_rsp.data <= {2'h0, idx_r[1]};
                    default:                reg_rsp.data <= 8'h00;
                endcase
            end
        end
    end

endmodule : lfd_fade_ctrl
`default_nettype wire

// File: sim/lfd_fade_ctrl_props.sv
`timescale 1ns/100ps
`default_nettype none
module lfd_chk #(
    parameter int unsigned DEBOUNCE_CYC = 20
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    // Register port
    input  wire lfd_pkg::lfd_reg_req_t reg_req,
    input  wire lfd_pkg::lfd_reg_rsp_t reg_rsp,
    // Pins and supply
    input  wire logic [1:0]            channel_enable_pins,
    input  wire logic [9:0]            rise_time_resistor_pin,
    input  wire logic [9:0]            fall_time_resistor_pin,
    input  wire logic                  supply_below_lock,
    input  wire logic                  supply_below_hold,
    input  wire logic                  supply_above_resume,
    // Outputs
    input  wire logic [1:0]            high_current_outputs
);
    logic        ext_r;
    logic        pwme_r;
    logic        lock_r;
    logic [7:0]  fon_r;
    logic [7:0]  sup_cnt;
    logic        pin_q;
    logic        soft_q;
    int unsigned pin_cnt;
    int unsigned soft_cnt;
    wire logic   rd_st = reg_req.rd && reg_req.addr == lfd_pkg::ADDR_STATUS;
    wire logic   unmap = !(reg_req.addr inside {8'h01, 8'h03, 8'h04, 8'h07, 8'h0B, 8'h0C, 8'h0D});

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // Register mirror
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ext_r  <= 1'b0;
            pwme_r <= lfd_pkg::CTRL_RST;
            fon_r  <= lfd_pkg::FADE_RST;
        end else if (reg_req.wr) begin
            if (reg_req.addr == lfd_pkg::ADDR_CFG)
                ext_r <= reg_req.wdata[lfd_pkg::CFG_PWMM_BIT];
            if (reg_req.addr == lfd_pkg::ADDR_CTRL)
                pwme_r <= reg_req.wdata[lfd_pkg::CTRL_PWME_BIT];
            if (reg_req.addr == lfd_pkg::ADDR_FADE_ON)
                fon_r <= reg_req.wdata;
        end
    end

    // Lockout state seen from the raw comparators
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            lock_r  <= 1'b0;
            sup_cnt <= 8'h00;
        end else begin
            if (supply_below_lock || supply_below_hold)
                lock_r <= 1'b1;
            else if (supply_above_resume)
                lock_r <= 1'b0;
            if (lock_r)
                sup_cnt <= 8'h00;
            else if (sup_cnt != 8'hFF)
                sup_cnt <= sup_cnt + 8'h01;
        end
    end

    // Cycles enable pin 0 and the soft bit have each stayed unchanged
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_q    <= 1'b0;
            soft_q   <= 1'b0;
            pin_cnt  <= 0;
            soft_cnt <= 0;
        end else begin
            pin_q    <= channel_enable_pins[0];
            soft_q   <= pwme_r;
            pin_cnt  <= (pin_q == channel_enable_pins[0]) ? pin_cnt + 1 : 0;
            soft_cnt <= (soft_q == pwme_r) ? soft_cnt + 1 : 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_ext_follow;
        (ext_r && $past(ext_r) && sup_cnt > 8'h08)
            |-> high_current_outputs == {2{$past(pwme_r)}};
    endproperty
    a_ext_follow: assert property (p_ext_follow)
        else $error("outputs do not follow the soft dim bit");

    property p_uvlo_off;
        lock_r [*5] |-> high_current_outputs == 2'h0;
    endproperty
    a_uvlo_off: assert property (p_uvlo_off)
        else $error("outputs on during lockout");

    property p_hold_clear;
        (supply_below_hold [*6] ##0 rd_st) |=> reg_rsp.data[1:0] == 2'h0;
    endproperty
    a_hold_clear: assert property (p_hold_clear)
        else $error("channel latch kept below hold level");

    property p_fon_read;
        (reg_req.rd && !reg_req.wr && reg_req.addr == lfd_pkg::ADDR_FADE_ON)
            |=> reg_rsp.valid && reg_rsp.data == fon_r;
    endproperty
    a_fon_read: assert property (p_fon_read)
        else $error("fade on time readback wrong");

    property p_idx_range;
        (reg_req.rd && reg_req.addr == lfd_pkg::ADDR_IDX1) |=> reg_rsp.data <= 8'h3E;
    endproperty
    a_idx_range: assert property (p_idx_range)
        else $error("gamma index beyond top");

    property p_pin_db;
        (rd_st && pin_cnt > DEBOUNCE_CYC + 6)
            |=> reg_rsp.data[4] == $past(channel_enable_pins[0], 2);
    endproperty
    a_pin_db: assert property (p_pin_db)
        else $error("debounced pin level wrong");

    property p_soft_db;
        (rd_st && soft_cnt > DEBOUNCE_CYC + 6) |=> reg_rsp.data[3] == $past(pwme_r, 2);
    endproperty
    a_soft_db: assert property (p_soft_db)
        else $error("debounced soft bit wrong");

    property p_unmap;
        (reg_req.rd && unmap) |=> reg_rsp.valid && reg_rsp.data == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");

    c_ext: cover property (ext_r && pwme_r && high_current_outputs == 2'h3);
    c_lock: cover property (lock_r && rd_st);
    c_full: cover property (!ext_r && high_current_outputs == 2'h3);
endmodule : lfd_chk

bind lfd_fade_ctrl lfd_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) i_lfd_chk (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .channel_enable_pins(channel_enable_pins),
    .rise_time_resistor_pin(rise_time_resistor_pin),
    .fall_time_resistor_pin(fall_time_resistor_pin),
    .supply_below_lock(supply_below_lock), .supply_below_hold(supply_below_hold),
    .supply_above_resume(supply_above_resume), .high_current_outputs(high_current_outputs)
);
`default_nettype wire

// File: sim/lfd_sw.sv
`timescale 1ns/100ps
`default_nettype none
module lfd_sw (
    // Clock
    input  wire logic       core_clk,
    // Wanted switch levels
    input  wire logic [1:0] target,
    // Pin levels with contact chatter
    output logic [1:0]      channel_enable_pins
);
    logic [1:0]  last_r = 2'h0;
    logic [1:0]  chg    = 2'h0;
    int unsigned bnc    = 0;

    // Chatter a few cycles on every change
    always @(negedge core_clk) begin
        if (target != last_r) begin
            chg    = target ^ last_r;
            last_r = target;
            bnc    = 7;
        end
        if (bnc != 0)
            bnc = bnc - 1;
        channel_enable_pins = bnc[0] ? target ^ chg : target;
    end
endmodule : lfd_sw
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int unsigned DB = 20;
    localparam logic [7:0]  RA [5] = '{8'h01, 8'h03, 8'h04, 8'h07, 8'h02};
    logic                  core_clk;
    logic                  rst_b;
    lfd_pkg::lfd_reg_req_t req;
    lfd_pkg::lfd_reg_rsp_t rsp;
    logic [1:0]            tgt;
    logic [1:0]            pins;
    logic [1:0]            outs;
    logic [9:0]            rk;
    logic [9:0]            fk;
    logic                  lock;
    logic                  hold;
    logic                  resume;
    logic [7:0]            d;
    logic [7:0]            v;
    int                    num_errors;
    int                    checks;

    lfd_sw i_lfd_sw (.core_clk(core_clk), .target(tgt), .channel_enable_pins(pins));
    lfd_fade_ctrl #(.DEBOUNCE_CYC(DB)) i_lfd_fade_ctrl (
        .core_clk(core_clk), .rst_b(rst_b), .reg_req(req), .reg_rsp(rsp),
        .channel_enable_pins(pins), .rise_time_resistor_pin(rk),
        .fall_time_resistor_pin(fk), .supply_below_lock(lock),
        .supply_below_hold(hold), .supply_above_resume(resume),
        .high_current_outputs(outs));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Resistor step length; 2.5 us per ohm, 75 us when grounded
    function automatic int unsigned step_res(input logic [9:0] k);
        return (k == 10'h000) ? 750 / 63 : k * 25000 / 63;
    endfunction : step_res

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge core_clk);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = dat;
        @(negedge core_clk);
        req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(negedge core_clk);
        req.rd   = 1'b1;
        req.addr = a;
        @(negedge core_clk);
        req.rd = 1'b0;
        chk("valid", 8'h01, {7'h00, rsp.valid});
        dat = rsp.data;
    endtask : rd

    task automatic wait_rd(input logic [7:0] a, input logic [7:0] e, input int n);
        logic [7:0] g;
        for (int i = 0; i < n; i++) begin
            rd(a, g);
            if (g === e) return;
        end
        chk("wait", e, g);
        results();
    endtask : wait_rd

    task automatic results();
        $display("mismatches %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        {tgt, rk, fk, lock, hold, rst_b} = '0;
        resume = 1'b1;
        repeat (5) @(negedge core_clk);
        rst_b = 1'b1;
        void'($urandom(2));
        foreach (RA[i]) begin
            rd(RA[i], d);
            chk("reset", 8'h00, d);
        end
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(lfd_pkg::ADDR_FADE_ON, v);
            rd(lfd_pkg::ADDR_FADE_ON, d);
            chk("fade_on", v, d);
        end
        // External dimming with random duty
        wr(lfd_pkg::ADDR_CFG, 8'h04);
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            wr(lfd_pkg::ADDR_CTRL, v);
            @(negedge core_clk);
            chk("ext", {6'h00, {2{v[0]}}}, {6'h00, outs});
        end
        for (int i = 1; i >= 0; i--) begin
            wr(lfd_pkg::ADDR_CTRL, 8'(i));
            repeat (16700) @(negedge core_clk);
            chk("ext_slow", 8'(3 * i), {6'h00, outs});
        end
        // Internal dimming, cancelled fades
        wr(lfd_pkg::ADDR_CFG, 8'h03);
        wr(lfd_pkg::ADDR_FADE_ON, 8'h00);
        wr(lfd_pkg::ADDR_FADE_OFF, 8'h00);
        wr(lfd_pkg::ADDR_CTRL, 8'h01);
        wait_rd(lfd_pkg::ADDR_IDX1, 8'h3E, 400);
        rd(lfd_pkg::ADDR_IDX2, d);
        chk("idx2", 8'h3E, d);
        chk("full", 8'h03, {6'h00, outs});
        wr(lfd_pkg::ADDR_CTRL, 8'h00);
        repeat (3) @(negedge core_clk);
        wr(lfd_pkg::ADDR_CTRL, 8'h01);
        repeat (DB * 3) @(negedge core_clk);
        rd(lfd_pkg::ADDR_IDX1, d);
        chk("glitch", 8'h3E, d);
        wr(lfd_pkg::ADDR_CTRL, 8'h00);
        wait_rd(lfd_pkg::ADDR_IDX1, 8'h00, 400);
        // Resistor ramp, reversed mid-way
        rk = 10'h001;
        fk = 10'h001;
        wr(lfd_pkg::ADDR_CFG, 8'h00);
        wr(lfd_pkg::ADDR_CTRL, 8'h01);
        repeat (DB + 5 * step_res(rk) + 60) @(negedge core_clk);
        rd(lfd_pkg::ADDR_IDX1, d);
        chk("ramp_up", 8'h05, d);
        wr(lfd_pkg::ADDR_CTRL, 8'h00);
        repeat (DB + 2 * step_res(fk) + 198) @(negedge core_clk);
        rd(lfd_pkg::ADDR_IDX1, d);
        chk("reverse", 8'h03, d);
        wait_rd(lfd_pkg::ADDR_IDX1, 8'h00, 800);
        // Level pin mode, channel one only
        wr(lfd_pkg::ADDR_CFG, 8'h03);
        tgt = 2'b01;
        wait_rd(lfd_pkg::ADDR_IDX1, 8'h3E, 400);
        rd(lfd_pkg::ADDR_IDX2, d);
        chk("ch2_idle", 8'h00, d);
        tgt = 2'b00;
        wait_rd(lfd_pkg::ADDR_IDX1, 8'h00, 400);
        // Falling-edge toggle mode on channel two, driven by a high pulse
        wr(lfd_pkg::ADDR_CFG, 8'h0B);
        tgt = 2'b10;
        repeat (DB * 2) @(negedge core_clk);
        tgt = 2'b00;
        wait_rd(lfd_pkg::ADDR_IDX2, 8'h3E, 400);
        rd(lfd_pkg::ADDR_IDX1, d);
        chk("ch1_idle", 8'h00, d);
        // Lockout keeps latch, resumes only above resume level
        lock = 1'b1;
        resume = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("lock", 8'h00, {6'h00, outs});
        rd(lfd_pkg::ADDR_STATUS, d);
        chk("latch", 8'h02, {6'h00, d[1:0]});
        lock = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("no_resume", 8'h00, {6'h00, outs});
        resume = 1'b1;
        repeat (8) @(negedge core_clk);
        chk("resume", 8'h02, {6'h00, outs});
        hold = 1'b1;
        lock = 1'b1;
        repeat (8) @(negedge core_clk);
        rd(lfd_pkg::ADDR_STATUS, d);
        chk("cleared", 8'h00, {6'h00, d[1:0]});
        {hold, lock} = 2'b00;
        repeat (10) @(negedge core_clk);
        chk("off", 8'h00, {6'h00, outs});
        results();
    end
endmodule : tb_top
`default_nettype wire
